//--- retrot_pkg.sv
// constants and types for the return and rotate execution block
package retrot_pkg;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 15;
  localparam int SP_W    = 4;
  localparam int DEPTH   = 16;
  localparam int IRQ_EN_BIT = 7;
  localparam logic [DATA_W-1:0] W_RST      = 8'h00;
  localparam logic [DATA_W-1:0] IRQCTL_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST     = 15'h0000;
  localparam logic [SP_W-1:0]   SP_RST     = 4'hf;
  localparam logic [SP_W-1:0]   SP_ONE     = 4'h1;
  localparam logic              DEST_W     = 1'b0;

  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_IRET  = 4'h1,
    OP_SRET  = 4'h2,
    OP_LRET  = 4'h3,
    OP_ROT   = 4'h4
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_POP2 = 2'b10
  } state_t;
endpackage

//--- ret_stack.sv
// return address stack with pop and push
`timescale 1ns/1ps
`default_nettype none
module ret_stack (
  // clock and reset
  input  wire logic                            CLK,
  input  wire logic                            RST_N,
  // control
  input  wire logic                            push,
  input  wire logic [retrot_pkg::PC_W-1:0]     push_addr,
  input  wire logic                            pop,
  // state
  output logic [retrot_pkg::PC_W-1:0]          top,
  output logic [retrot_pkg::SP_W-1:0]          sp
);
  logic [retrot_pkg::PC_W-1:0] mem [retrot_pkg::DEPTH];
  logic [retrot_pkg::SP_W-1:0] sp_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sp_q <= retrot_pkg::SP_RST;
    end else if (push) begin
      sp_q <= sp_q + retrot_pkg::SP_ONE;
    end else if (pop) begin
      sp_q <= sp_q - retrot_pkg::SP_ONE;
    end
  end

  // contents need no reset; pointer alone defines validity
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[sp_q + retrot_pkg::SP_ONE] <= push_addr;
    end
  end

  assign top = mem[sp_q];
  assign sp  = sp_q;

  pop_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
    pop && !push |=> sp_q == $past(sp_q) - retrot_pkg::SP_ONE)
    else $error("stack pointer did not step back on pop");
endmodule // ret_stack
`default_nettype wire

//--- retrot_exec.sv
// execution of returns and rotate-left-through-carry
`timescale 1ns/1ps
`default_nettype none
module retrot_exec (
  // clock and reset
  input  wire logic                              CLK,
  input  wire logic                              RST_N,
  // decoded instruction
  input  wire logic                              OP_VALID,
  input  wire retrot_pkg::op_t                   OP,
  input  wire logic [retrot_pkg::DATA_W-1:0]     LITERAL,
  input  wire logic                              DEST_SEL,
  input  wire logic [retrot_pkg::DATA_W-1:0]     FILE_RD_DATA,
  // stack push from call logic
  input  wire logic                              PUSH,
  input  wire logic [retrot_pkg::PC_W-1:0]       PUSH_ADDR,
  // core state
  output logic                                   BUSY,
  output logic                                   DONE,
  output logic [retrot_pkg::PC_W-1:0]            PC,
  output logic [retrot_pkg::DATA_W-1:0]          W_REG,
  output logic [retrot_pkg::DATA_W-1:0]          IRQ_CONTROL_REG,
  output logic                                   CARRY,
  output logic                                   FILE_WR_EN,
  output logic [retrot_pkg::DATA_W-1:0]          FILE_WR_DATA,
  output logic [retrot_pkg::SP_W-1:0]            STACK_PTR
);
  retrot_pkg::state_t          state_q;
  retrot_pkg::op_t             op_q;
  logic [retrot_pkg::PC_W-1:0] pc_q;
  logic [retrot_pkg::PC_W-1:0] stack_top_entry;
  logic [retrot_pkg::DATA_W-1:0] w_q;
  logic [retrot_pkg::DATA_W-1:0] irq_ctl_q;
  logic [retrot_pkg::DATA_W-1:0] rot_d;
  logic [retrot_pkg::DATA_W-1:0] fwd_q;
  logic                          carry_q;
  logic                          fwe_q;
  logic                          done_q;
  logic                          accept;
  logic                          pop;

  // all checks here live on the one instruction clock
  default clocking cb_exec @(posedge CLK); endclocking
  default disable iff (!RST_N);

  function automatic logic is_ret(input retrot_pkg::op_t o);
    return o == retrot_pkg::OP_IRET || o == retrot_pkg::OP_SRET ||
           o == retrot_pkg::OP_LRET;
  endfunction

  assign accept = OP_VALID && state_q == retrot_pkg::ST_IDLE;
  // pop in the second cycle so the popped top is what lands in pc
  assign pop    = state_q == retrot_pkg::ST_POP2;

  ret_stack u_stack (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .push      (PUSH && !pop),
    .push_addr (PUSH_ADDR),
    .pop       (pop),
    .top       (stack_top_entry),
    .sp        (STACK_PTR)
  );

  //////////////////////////////////////////////////////////////////////
  // sequencing: returns take two cycles, rotate one
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= retrot_pkg::ST_IDLE;
      op_q    <= retrot_pkg::OP_NONE;
    end else begin
      unique case (state_q)
        retrot_pkg::ST_IDLE: begin
          if (accept && is_ret(OP)) begin
            state_q <= retrot_pkg::ST_POP2;
            op_q    <= OP;
          end
        end
        retrot_pkg::ST_POP2: begin
          state_q <= retrot_pkg::ST_IDLE;
        end
        default: state_q <= retrot_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      done_q <= 1'b0;
    end else begin
      done_q <= pop || (accept && OP == retrot_pkg::OP_ROT);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // program counter from top of stack
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pc_q <= retrot_pkg::PC_RST;
    end else if (pop) begin
      pc_q <= stack_top_entry;
    end
  end

  // global enable set on interrupt return only
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_ctl_q <= retrot_pkg::IRQCTL_RST;
    end else if (pop && op_q == retrot_pkg::OP_IRET) begin
      irq_ctl_q[retrot_pkg::IRQ_EN_BIT] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // rotate datapath
  assign rot_d = {FILE_RD_DATA[retrot_pkg::DATA_W-2:0], carry_q};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      w_q <= retrot_pkg::W_RST;
    end else if (accept && OP == retrot_pkg::OP_LRET) begin
      w_q <= LITERAL;
    end else if (accept && OP == retrot_pkg::OP_ROT &&
                 DEST_SEL == retrot_pkg::DEST_W) begin
      w_q <= rot_d;
    end
  end

  // carry is the only flag this block touches
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      carry_q <= 1'b0;
    end else if (accept && OP == retrot_pkg::OP_ROT) begin
      carry_q <= FILE_RD_DATA[retrot_pkg::DATA_W-1];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fwe_q <= 1'b0;
      fwd_q <= retrot_pkg::W_RST;
    end else begin
      fwe_q <= accept && OP == retrot_pkg::OP_ROT &&
               DEST_SEL != retrot_pkg::DEST_W;
      fwd_q <= rot_d;
    end
  end

  assign BUSY            = state_q == retrot_pkg::ST_POP2;
  assign DONE            = done_q;
  assign PC              = pc_q;
  assign W_REG           = w_q;
  assign IRQ_CONTROL_REG = irq_ctl_q;
  assign CARRY           = carry_q;
  assign FILE_WR_EN      = fwe_q;
  assign FILE_WR_DATA    = fwd_q;

  //////////////////////////////////////////////////////////////////////
  ret_two_cyc_a: assert property (
    accept && is_ret(OP) |=> BUSY ##1 (DONE && !BUSY))
    else $error("return did not finish in two cycles");
  ret_pc_load_a: assert property (
    pop |=> pc_q == $past(stack_top_entry))
    else $error("pc not loaded from top of stack");
  irq_en_set_a: assert property (
    pop && op_q == retrot_pkg::OP_IRET |=>
    irq_ctl_q[retrot_pkg::IRQ_EN_BIT])
    else $error("global enable not set");
  ret_flag_kept_a: assert property (
    accept && is_ret(OP) |=> $stable(carry_q) [*2])
    else $error("return changed carry");
  lit_to_w_a: assert property (
    accept && OP == retrot_pkg::OP_LRET |=> w_q == $past(LITERAL))
    else $error("literal not in working register");
  lit_pc_a: assert property (
    accept && OP == retrot_pkg::OP_LRET ##1 1'b1 |=>
    pc_q == $past(stack_top_entry))
    else $error("literal return did not reload pc");
  rot_result_a: assert property (
    accept && OP == retrot_pkg::OP_ROT && DEST_SEL != retrot_pkg::DEST_W |=>
    FILE_WR_EN && carry_q == $past(FILE_RD_DATA[retrot_pkg::DATA_W-1]) &&
    FILE_WR_DATA == {$past(FILE_RD_DATA[retrot_pkg::DATA_W-2:0]),
                     $past(carry_q)} && $stable(w_q))
    else $error("rotate to file wrong");
  rot_dest_w_a: assert property (
    accept && OP == retrot_pkg::OP_ROT && DEST_SEL == retrot_pkg::DEST_W |=>
    !FILE_WR_EN && DONE &&
    w_q == {$past(FILE_RD_DATA[retrot_pkg::DATA_W-2:0]), $past(carry_q)})
    else $error("rotate to working register wrong");

  cov_iret_c: cover property (pop && op_q == retrot_pkg::OP_IRET);
  cov_lret_c: cover property (pop && op_q == retrot_pkg::OP_LRET);
  cov_rotf_c: cover property (FILE_WR_EN);
  cov_rotw_c: cover property (accept && OP == retrot_pkg::OP_ROT &&
                              DEST_SEL == retrot_pkg::DEST_W);
endmodule // retrot_exec
`default_nettype wire

//--- tb_top.sv
// self-checking testbench for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                          CLK = 1'b0;
  logic                          RST_N = 1'b0;
  logic                          OP_VALID = 1'b0;
  retrot_pkg::op_t               OP = retrot_pkg::OP_NONE;
  logic [retrot_pkg::DATA_W-1:0] LITERAL = 8'h00;
  logic                          DEST_SEL = 1'b0;
  logic [retrot_pkg::DATA_W-1:0] FILE_RD_DATA = 8'h00;
  logic                          PUSH = 1'b0;
  logic [retrot_pkg::PC_W-1:0]   PUSH_ADDR = 15'h0000;
  logic                          BUSY, DONE, CARRY, FILE_WR_EN;
  logic [retrot_pkg::PC_W-1:0]   PC;
  logic [retrot_pkg::DATA_W-1:0] W_REG, IRQ_CONTROL_REG, FILE_WR_DATA;
  logic [retrot_pkg::SP_W-1:0]   STACK_PTR;
  int                            num_errors = 0;
  int                            compares = 0;
  int                            lat;
  logic                          busy_seen;

  always #10 CLK = ~CLK;

  retrot_exec i_retrot_exec (.CLK(CLK), .RST_N(RST_N),
    .OP_VALID(OP_VALID), .OP(OP), .LITERAL(LITERAL), .DEST_SEL(DEST_SEL),
    .FILE_RD_DATA(FILE_RD_DATA), .PUSH(PUSH), .PUSH_ADDR(PUSH_ADDR),
    .BUSY(BUSY), .DONE(DONE), .PC(PC), .W_REG(W_REG),
    .IRQ_CONTROL_REG(IRQ_CONTROL_REG), .CARRY(CARRY),
    .FILE_WR_EN(FILE_WR_EN), .FILE_WR_DATA(FILE_WR_DATA),
    .STACK_PTR(STACK_PTR));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // latency counted from the accept edge; bounded so a hang cannot stall
  task automatic run_op(input retrot_pkg::op_t op, input logic [7:0] lit,
                        input logic dest, input logic [7:0] fd);
    @(posedge CLK);
    OP_VALID <= 1'b1;
    OP <= op;
    LITERAL <= lit;
    DEST_SEL <= dest;
    FILE_RD_DATA <= fd;
    @(posedge CLK);
    OP_VALID <= 1'b0;
    OP <= retrot_pkg::OP_NONE;
    lat = 1;
    busy_seen = 1'b0;
    #1;
    while (DONE !== 1'b1 && lat < 6) begin
      busy_seen = busy_seen | (BUSY === 1'b1);
      @(posedge CLK);
      #1;
      lat++;
    end
  endtask

  task automatic do_push(input logic [14:0] a, input logic [3:0] e);
    @(posedge CLK);
    PUSH <= 1'b1;
    PUSH_ADDR <= a;
    @(posedge CLK);
    PUSH <= 1'b0;
    #1;
    chk(16'(STACK_PTR), 16'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_rotate_file();
    run_op(retrot_pkg::OP_ROT, 8'h00, 1'b1, 8'h35);
    chk(16'(lat), 16'h0001);
    chk(16'(FILE_WR_EN), 16'h0001);
    chk(16'(FILE_WR_DATA), 16'h006a);
    chk(16'(CARRY), 16'h0000);
    chk(16'(W_REG), 16'h0000);
    @(posedge CLK);
    #1;
    chk(16'(FILE_WR_EN), 16'h0000);
  endtask

  task automatic t_rotate_w();
    run_op(retrot_pkg::OP_ROT, 8'h00, 1'b0, 8'he6);
    chk(16'(W_REG), 16'h00cc);
    chk(16'(CARRY), 16'h0001);
    chk(16'(FILE_WR_EN), 16'h0000);
    // carry now set: it must enter bit 0 and the new carry come from bit 7
    run_op(retrot_pkg::OP_ROT, 8'h00, 1'b1, 8'h81);
    chk(16'(FILE_WR_EN), 16'h0001);
    chk(16'(FILE_WR_DATA), 16'h0003);
    chk(16'(CARRY), 16'h0001);
    chk(16'(W_REG), 16'h00cc);
  endtask

  task automatic t_lit_return();
    run_op(retrot_pkg::OP_LRET, 8'ha5, 1'b0, 8'h00);
    chk(16'(lat), 16'h0002);
    chk(16'(busy_seen), 16'h0001);
    chk(16'(W_REG), 16'h00a5);
    chk(16'(PC), 16'h0abc);
    chk(16'(STACK_PTR), 16'h0000);
    chk(16'(CARRY), 16'h0001);
  endtask

  task automatic t_irq_return();
    run_op(retrot_pkg::OP_IRET, 8'h00, 1'b0, 8'h00);
    chk(16'(lat), 16'h0002);
    chk(16'(busy_seen), 16'h0001);
    chk(16'(PC), 16'h1234);
    chk(16'(IRQ_CONTROL_REG), 16'h0080);
    chk(16'(STACK_PTR), 16'h000f);
    chk(16'(CARRY), 16'h0001);
  endtask

  task automatic t_sub_return();
    do_push(15'h7001, 4'h0);
    run_op(retrot_pkg::OP_SRET, 8'h00, 1'b0, 8'h00);
    chk(16'(lat), 16'h0002);
    chk(16'(PC), 16'h7001);
    chk(16'(STACK_PTR), 16'h000f);
    chk(16'(CARRY), 16'h0001);
    chk(16'(W_REG), 16'h00a5);
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    #1;
    chk(16'(STACK_PTR), 16'h000f);
    chk(16'(PC), 16'h0000);
    do_push(15'h1234, 4'h0);
    do_push(15'h0abc, 4'h1);
    t_rotate_file();
    t_rotate_w();
    t_lit_return();
    t_irq_return();
    t_sub_return();
    final_report();
  end

  // whole run needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge CLK);
    num_errors++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
